// File: flash_access_waitstate_control.sv
// flash read access timing and program/erase duration supervision
// Functional notes
// - a flash read lasts one cycle plus the programmed wait count.
// - wait field code 00 gives zero, 01 one and 10 two waitstates.
// - waitstates are added only on non-sequential reads; sequential reads finish in one cycle.
// - a 128-byte block program is bounded to at most 5 ms.
// - a sector erase is bounded to at most 500 ms.
`default_nettype none
module flash_access_waitstate_control #(
  parameter int PROG_LIMIT  = flash_wait_pkg::PROG_MAX_CYC,
  parameter int ERASE_LIMIT = flash_wait_pkg::ERASE_MAX_CYC
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic [1:0]                   i_flash_wait_count_field,
  input  wire flash_wait_pkg::read_req_type i_read,
  input  wire logic                         i_prog_start,
  input  wire logic                         i_erase_start,
  input  wire logic                         i_array_done,
  output var  logic                         o_read_done,
  output var  logic [23:0]                  o_read_addr,
  output var  logic                         o_busy,
  output var  logic                         o_op_done,
  output var  logic                         o_op_timeout,
  output var  logic [1:0]                   o_wait_count
);
  flash_wait_pkg::state_type state_reg;
  flash_wait_pkg::state_type state_next;

  // combinational helpers
  logic [1:0]  wait_sel;     // decoded wait count for the current field value
  logic [29:0] limit;        // cycle bound of the operation in flight
  logic        idle;         // nothing in flight, new requests may be taken
  logic        take_prog;    // program start accepted this cycle
  logic        take_erase;   // erase start accepted this cycle
  logic        take_read;    // read accepted this cycle
  logic        read_fast;    // accepted read needs no waitstates
  logic        read_last;    // last waitstate of a read in flight
  logic        limit_hit;    // running operation reached its bound
  logic [29:0] count_inc;    // operation counter plus one

  // decode wait field; the reserved code falls back to the slowest timing for safety
  // a field change takes effect on the next request, never on a read in flight
  always_comb
  begin
    unique case (i_flash_wait_count_field)
      flash_wait_pkg::WAIT_ZERO:
      begin
        wait_sel = 2'h0;
      end
      flash_wait_pkg::WAIT_ONE:
      begin
        wait_sel = 2'h1;
      end
      flash_wait_pkg::WAIT_TWO:
      begin
        wait_sel = 2'h2;
      end
      flash_wait_pkg::WAIT_RSVD:
      begin
        wait_sel = flash_wait_pkg::WAIT_MAX;
      end
    endcase
  end

  // request arbitration: program wins over erase and erase over read,
  // so at most one start is taken per cycle and nothing is taken while busy
  always_comb
  begin
    idle       = (state_reg.mode == flash_wait_pkg::ST_IDLE);
    take_prog  = idle && i_prog_start;
    take_erase = idle && !i_prog_start && i_erase_start;
    take_read  = idle && !i_prog_start && !i_erase_start && i_read.valid;
    read_fast  = i_read.sequential || (wait_sel == 2'h0);
    read_last  = (state_reg.wait_left == 2'h1);
  end

  // operation bound: the limit follows the kind of operation in flight
  // compare against limit-1 so the timeout pulse lands after exactly limit busy cycles
  always_comb
  begin
    if (state_reg.mode == flash_wait_pkg::ST_PROG)
    begin
      limit = 30'(PROG_LIMIT);
    end
    else
    begin
      limit = 30'(ERASE_LIMIT);
    end
    limit_hit = (state_reg.op_count >= limit - 30'h1);
    count_inc = state_reg.op_count + 30'h1;
  end

  // next-state logic; pulses default low so each lasts exactly one cycle
  always_comb
  begin
    state_next            = state_reg;
    state_next.read_done  = 1'b0;
    state_next.op_done    = 1'b0;
    state_next.op_timeout = 1'b0;
    state_next.wait_count = wait_sel;

    // hold everything else; only the branch below moves state
    unique case (state_reg.mode)
      flash_wait_pkg::ST_IDLE:
      begin
        // a program start opens the block-program supervision window
        if (take_prog)
        begin
          state_next.mode     = flash_wait_pkg::ST_PROG;
          state_next.op_count = 30'h0000_0000;
          state_next.busy     = 1'b1;
        end
        // a sector erase opens the longer erase supervision window
        else if (take_erase)
        begin
          state_next.mode     = flash_wait_pkg::ST_ERASE;
          state_next.op_count = 30'h0000_0000;
          state_next.busy     = 1'b1;
        end
        // a read is only taken when no start competes in the same cycle
        else if (take_read)
        begin
          state_next.addr = i_read.addr;
          // sequential fetches come from the prefetch path, so no waitstates
          if (read_fast)
          begin
            state_next.read_done = 1'b1;
          end
          else
          begin
            // waitstates still to run before the data is valid
            state_next.mode      = flash_wait_pkg::ST_READ;
            state_next.wait_left = wait_sel;
            state_next.busy      = 1'b1;
          end
        end
      end
      flash_wait_pkg::ST_READ:
      begin
        // done pulse lands wait_count cycles after the request edge
        // the count was latched at the request, so a field change cannot stretch it
        if (read_last)
        begin
          state_next.read_done = 1'b1;
          state_next.mode      = flash_wait_pkg::ST_IDLE;
          state_next.busy      = 1'b0;
        end
        state_next.wait_left = state_reg.wait_left - 2'h1;
      end
      flash_wait_pkg::ST_PROG:
      begin
        // the array ack ends the program; the bound stops a hung array
        if (i_array_done)
        begin
          state_next.op_done = 1'b1;
          state_next.mode    = flash_wait_pkg::ST_IDLE;
          state_next.busy    = 1'b0;
        end
        else if (limit_hit)
        begin
          state_next.op_timeout = 1'b1;
          state_next.mode       = flash_wait_pkg::ST_IDLE;
          state_next.busy       = 1'b0;
        end
        else
        begin
          state_next.op_count = count_inc;
        end
      end
      flash_wait_pkg::ST_ERASE:
      begin
        // the array ack ends the erase; the bound stops a hung array
        if (i_array_done)
        begin
          state_next.op_done = 1'b1;
          state_next.mode    = flash_wait_pkg::ST_IDLE;
          state_next.busy    = 1'b0;
        end
        else if (limit_hit)
        begin
          state_next.op_timeout = 1'b1;
          state_next.mode       = flash_wait_pkg::ST_IDLE;
          state_next.busy       = 1'b0;
        end
        else
        begin
          state_next.op_count = count_inc;
        end
      end
    endcase
  end

  // single state register; the reset wait count is the slowest, safe for any clock
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg.mode       <= flash_wait_pkg::ST_IDLE;
      state_reg.wait_count <= flash_wait_pkg::WAIT_RESET;
      state_reg.wait_left  <= 2'h0;
      state_reg.op_count   <= 30'h0000_0000;
      state_reg.read_done  <= 1'b0;
      state_reg.op_done    <= 1'b0;
      state_reg.op_timeout <= 1'b0;
      state_reg.busy       <= 1'b0;
      state_reg.addr       <= 24'h00_0000;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // read side outputs straight from the state register
  assign o_read_done  = state_reg.read_done;
  assign o_read_addr  = state_reg.addr;
  assign o_wait_count = state_reg.wait_count;

  // array operation outputs straight from the state register
  assign o_busy       = state_reg.busy;
  assign o_op_done    = state_reg.op_done;
  assign o_op_timeout = state_reg.op_timeout;
endmodule
`default_nettype wire

// File: flash_wait_pkg.sv
// package: constants and carriers for the flash access wait control block
`default_nettype none
package flash_wait_pkg;
  localparam logic [1:0] WAIT_ZERO  = 2'h0;
  localparam logic [1:0] WAIT_ONE   = 2'h1;
  localparam logic [1:0] WAIT_TWO   = 2'h2;
  localparam logic [1:0] WAIT_RSVD  = 2'h3;
  localparam logic [1:0] WAIT_MAX   = 2'h2;
  localparam int CLK_NS            = 4;
  localparam int PROG_MAX_MS       = 5;
  localparam int ERASE_MAX_MS      = 500;
  localparam int PROG_MAX_CYC      = PROG_MAX_MS * 1000000 / CLK_NS;
  localparam int ERASE_MAX_CYC     = ERASE_MAX_MS * 1000000 / CLK_NS;
  localparam int BLOCK_BYTES       = 128;
  localparam logic [1:0] WAIT_RESET = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_PROG = 2'b10,
    ST_ERASE = 2'b11
  } mode_type;

  typedef struct packed {
    logic        valid;
    logic        sequential;
    logic [23:0] addr;
  } read_req_type;

  typedef struct packed {
    mode_type    mode;
    logic [1:0]  wait_count;
    logic [1:0]  wait_left;
    logic [29:0] op_count;
    logic        read_done;
    logic        op_done;
    logic        op_timeout;
    logic        busy;
    logic [23:0] addr;
  } state_type;
endpackage
`default_nettype wire

// File: flash_wait_assertions.sv
// checker for flash read timing and wait code decoding
`default_nettype none
module flash_wait_assertions (
  input wire logic                         i_clk,
  input wire logic                         i_rst,
  input wire logic [1:0]                   i_flash_wait_count_field,
  input wire flash_wait_pkg::read_req_type i_read,
  input wire logic                         i_prog_start,
  input wire logic                         i_erase_start,
  input wire logic                         o_read_done,
  input wire logic                         o_busy,
  input wire logic [1:0]                   o_wait_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a read is taken only when idle and no program or erase start competes
  wire logic rq = i_read.valid && !o_busy && !i_prog_start && !i_erase_start;
  wire logic nq = rq && !i_read.sequential;
  AST_WAIT0: assert property (nq && o_wait_count == 2'h0 |=> o_read_done)
    else $error("zero wait read late");
  AST_WAIT1: assert property (nq && o_wait_count == 2'h1 |=> !o_read_done ##1 o_read_done)
    else $error("one wait read timing wrong");
  AST_WAIT2: assert property (nq && o_wait_count == 2'h2 |=> !o_read_done [*2] ##1 o_read_done)
    else $error("two wait read timing wrong");
  AST_SEQ: assert property (rq && i_read.sequential |=> o_read_done)
    else $error("sequential read delayed");
  AST_RSVD: assert property (i_flash_wait_count_field == 2'h3 |=> o_wait_count == 2'h2)
    else $error("reserved code not at maximum");
  AST_CODE: assert property (i_flash_wait_count_field != 2'h3 |=> o_wait_count == $past(i_flash_wait_count_field))
    else $error("wait code decode wrong");
  AST_PROG: assert property (i_prog_start && !o_busy |=> o_busy)
    else $error("program not started");
  AST_ERASE: assert property (i_erase_start && !o_busy |=> o_busy)
    else $error("erase not started");
endmodule
bind flash_access_waitstate_control flash_wait_assertions chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_flash_wait_count_field(i_flash_wait_count_field), .i_read(i_read),
  .i_prog_start(i_prog_start), .i_erase_start(i_erase_start), .o_read_done(o_read_done),
  .o_busy(o_busy), .o_wait_count(o_wait_count));
`default_nettype wire

// File: cpu_fetch_model.sv
// cpu fetch model issuing single flash reads
`default_nettype none
module cpu_fetch_model (
  input  wire logic                         i_clk,
  output var  flash_wait_pkg::read_req_type o_read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_read = '0;
  // one-cycle request; released address is inverted so stale values never match
  task automatic fetch(input logic s, input logic [23:0] a);
    @(negedge i_clk) o_read = '{1'b1, s, a};
    @(negedge i_clk) o_read = '{1'b0, 1'b0, ~a};
  endtask
endmodule
`default_nettype wire

// File: flash_access_waitstate_control_tb.sv
// testbench for flash access wait control
`default_nettype none
module flash_access_waitstate_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ps = 0, es = 0, ad = 0, done, bsy, opd, opt;
  logic [1:0] fld = 2'h0, wc;
  logic [23:0] ra;
  flash_wait_pkg::read_req_type rd;
  int fail_count = 0, check_count = 0, n;
  always #2 clk = ~clk;
  cpu_fetch_model cpu_u (.i_clk(clk), .o_read(rd));
  flash_access_waitstate_control #(.PROG_LIMIT(20), .ERASE_LIMIT(40)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_flash_wait_count_field(fld), .i_read(rd),
    .i_prog_start(ps), .i_erase_start(es), .i_array_done(ad), .o_read_done(done),
    .o_read_addr(ra), .o_busy(bsy), .o_op_done(opd), .o_op_timeout(opt), .o_wait_count(wc));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  // every wait code non-sequential, then a sequential read at two waits
  task automatic t_reads();
    for (int c = 0; c < 5; c++)
    begin
      @(negedge clk) fld = (c == 4) ? 2'h2 : c[1:0];
      repeat (3) @(negedge clk);
      cpu_u.fetch(c == 4, 24'h00a5_0000 + c);
      for (n = 1; done !== 1'b1 && n < 9; n++) @(negedge clk);
      chk("read cycles", n, (c == 4) ? 1 : (c == 3) ? 3 : c + 1);
      chk("read addr", ra, 24'h00a5_0000 + c);
    end
    $display("reads finished");
  endtask
  // array finishes well inside the bound
  task automatic t_prog();
    @(negedge clk) ps = 1;
    @(negedge clk) ps = 0;
    repeat (4) @(negedge clk);
    ad = 1;
    @(negedge clk) ad = 0;
    chk("prog end", {bsy, opd}, 2'h1);
    $display("program finished");
  endtask
  // array never answers, so the bound must end the erase
  task automatic t_erase();
    @(negedge clk) es = 1;
    @(negedge clk) es = 0;
    for (n = 1; opt !== 1'b1 && n < 60; n++) @(negedge clk);
    chk("erase bound", n, 41);
    chk("erase end", {opt, opd}, 2'h2);
    $display("erase finished");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_reads();
    t_prog();
    t_erase();
    end_of_test();
  end
  // watchdog far beyond the roughly ninety cycles the tests need
  initial
  begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
